// ### core/spc_sync_protection_control.sv
// Write-only protection count and control registers plus the block and frame
// sync protection state machines.
// Assumes timing events and judgements arrive from logic on core_clk_i.
`timescale 1ns/1ps

module spc_sync_protection_control (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Host register writes, one-cycle strobe
  input  wire logic       wr_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  // Error limits for identification code agreement
  input  wire logic [3:0] synced_err_limit_i,
  input  wire logic [3:0] unsynced_err_limit_i,
  // Block timing from the internal free-running counter
  input  wire logic       block_tick_i,
  input  wire logic       code_found_i,
  input  wire logic [3:0] code_errors_i,
  // Frame timing from the internal frame counter
  input  wire logic       frame_tick_i,
  input  wire logic       frame_agree_i,
  // Datapath signals gated by the control register, except serial data, which passes ungated
  input  wire logic       event_strobe_i,
  input  wire logic       serial_data_i,
  input  wire logic       serial_active_i,
  input  wire logic       pkt_valid_i,
  input  wire logic       pkt_corrected_i,
  input  wire logic       pkt_crc_ok_i,
  output logic            block_sync_o,
  output logic            frame_sync_o,
  output logic            upper_crc_checker_reset_o,
  output logic            correction_enable_o,
  output logic            column_correction_enable_o,
  output logic            method_a_o,
  output logic            no_realtime_blocks_o,
  output logic            event_strobe_o,
  output logic            serial_data_o,
  output logic            serial_oe_o,
  output logic            pkt_emit_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           block_counts;
    logic [7:0]           frame_counts;
    logic [7:0]           ctl;
    spc_pkg::spc_prot_type blk;
    spc_pkg::spc_prot_type frm;
    logic                 no_realtime_blocks_drop;
    logic                 block_sync;
    logic                 frame_sync;
    logic                 crc_rst;
    logic                 corr_en;
    logic                 col_en;
    logic                 method_a;
    logic                 no_no_realtime_blocks;
    logic                 strobe;
    logic                 sdata;
    logic                 soe;
    logic                 emit;
  } spc_state_type;

  spc_state_type q;
  spc_state_type next_q;

  // ----------------------------------------------------------------
  // Protection step, shared by block and frame
  // ----------------------------------------------------------------
  function automatic spc_pkg::spc_prot_type spc_prot_step(
    input spc_pkg::spc_prot_type cur,
    input logic                  tick,
    input logic                  agree,
    input logic [7:0]            counts
  );
    spc_pkg::spc_prot_type res;
    logic [3:0]            bwd;
    logic [3:0]            fwd;
    res = cur;
    bwd = counts[spc_pkg::BACKWARD_MSB:spc_pkg::BACKWARD_LSB];
    fwd = counts[spc_pkg::FORWARD_MSB:spc_pkg::FORWARD_LSB];
    if (tick) begin
      if (cur.sync == spc_pkg::SPC_UNSYNC) begin
        if (!agree) begin
          res.cnt = 4'h0;
        end else if (cur.cnt == bwd) begin
          res.sync = spc_pkg::SPC_SYNCED;
          res.cnt  = 4'h0;
        end else begin
          res.cnt = cur.cnt + 4'h1;
        end
      end else begin
        if (agree) begin
          res.cnt = 4'h0;
        end else if (cur.cnt == fwd) begin
          res.sync = spc_pkg::SPC_UNSYNC;
          res.cnt  = 4'h0;
        end else begin
          res.cnt = cur.cnt + 4'h1;
        end
      end
    end
    return res;
  endfunction : spc_prot_step

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       blk_agree;
  logic [3:0] err_limit;
  logic       srst;
  logic       frm_agree;

  always_comb begin
    next_q    = q;
    srst      = q.ctl[spc_pkg::SYNC_RESET_BIT];
    err_limit = (q.blk.sync == spc_pkg::SPC_SYNCED) ? synced_err_limit_i : unsynced_err_limit_i;
    blk_agree = code_found_i && (code_errors_i <= err_limit);
    frm_agree = frame_agree_i && !q.no_realtime_blocks_drop;

    if (wr_i) begin
      unique case (addr_i)
        spc_pkg::BLOCK_COUNTS_ADDR: next_q.block_counts = wdata_i;
        spc_pkg::FRAME_COUNTS_ADDR: next_q.frame_counts = wdata_i;
        spc_pkg::MAIN_CONTROL_ADDR: next_q.ctl = wdata_i;
        default: ;
      endcase
    end

    next_q.blk = spc_prot_step(q.blk, block_tick_i, blk_agree, q.block_counts);
    next_q.frm = spc_prot_step(q.frm, frame_tick_i, frm_agree, q.frame_counts);

    // Changed block layout: frame sync runs out its forward count
    if (q.ctl[spc_pkg::NO_NO_REALTIME_BLOCKS_BIT] != q.no_no_realtime_blocks && q.frm.sync == spc_pkg::SPC_SYNCED) begin
      next_q.no_realtime_blocks_drop = 1'b1;
    end else if (q.frm.sync == spc_pkg::SPC_UNSYNC) begin
      next_q.no_realtime_blocks_drop = 1'b0;
    end

    if (srst) begin
      next_q.blk       = '{sync: spc_pkg::SPC_UNSYNC, cnt: 4'h0};
      next_q.frm       = '{sync: spc_pkg::SPC_UNSYNC, cnt: 4'h0};
      next_q.no_realtime_blocks_drop = 1'b0;
    end

    next_q.block_sync = (q.blk.sync == spc_pkg::SPC_SYNCED);
    next_q.frame_sync = (q.frm.sync == spc_pkg::SPC_SYNCED);
    next_q.crc_rst    = q.ctl[spc_pkg::CRC_RESET_BIT];
    next_q.corr_en    = !q.ctl[spc_pkg::SHUTDOWN_BIT];
    next_q.col_en     = !q.ctl[spc_pkg::SHUTDOWN_BIT] && !q.ctl[spc_pkg::COLUMN_DISABLE_BIT];
    next_q.method_a   = q.ctl[spc_pkg::METHOD_A_BIT];
    next_q.no_no_realtime_blocks    = q.ctl[spc_pkg::NO_NO_REALTIME_BLOCKS_BIT];
    next_q.strobe     = event_strobe_i && !srst;
    next_q.sdata      = serial_data_i;
    next_q.soe        = !srst && !q.ctl[spc_pkg::SHUTDOWN_BIT]
                        && (q.ctl[spc_pkg::PIN_MODE_BIT] || serial_active_i);
    next_q.emit       = pkt_valid_i && !srst && !q.ctl[spc_pkg::SHUTDOWN_BIT]
                        && (q.ctl[spc_pkg::EMIT_ALL_BIT]
                            || (q.blk.sync == spc_pkg::SPC_SYNCED && q.frm.sync == spc_pkg::SPC_SYNCED
                                && pkt_corrected_i && pkt_crc_ok_i));
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q              <= '0;
      q.block_counts <= spc_pkg::BLOCK_COUNTS_RESET;
      q.frame_counts <= spc_pkg::FRAME_COUNTS_RESET;
      q.ctl          <= spc_pkg::MAIN_CONTROL_RESET;
      q.corr_en      <= 1'b1;
      q.col_en       <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign block_sync_o               = q.block_sync;
  assign frame_sync_o               = q.frame_sync;
  assign upper_crc_checker_reset_o  = q.crc_rst;
  assign correction_enable_o        = q.corr_en;
  assign column_correction_enable_o = q.col_en;
  assign method_a_o                 = q.method_a;
  assign no_realtime_blocks_o       = q.no_no_realtime_blocks;
  assign event_strobe_o             = q.strobe;
  assign serial_data_o              = q.sdata;
  assign serial_oe_o                = q.soe;
  assign pkt_emit_o                 = q.emit;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking spc_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_block_count_reset: assert property ($fell(rst_i) |-> q.block_counts == 8'h17)
    else $error("block counts not at reset value");
  a_frame_count_reset: assert property ($fell(rst_i) |-> q.frame_counts == 8'h17)
    else $error("frame counts not at reset value");
  a_unsync_agree_incr: assert property (
    q.blk.sync == spc_pkg::SPC_UNSYNC && block_tick_i && blk_agree && !srst
      && q.blk.cnt != q.block_counts[7:4] |=> q.blk.cnt == $past(q.blk.cnt) + 4'h1)
    else $error("unsynced counter did not increment");
  a_unsync_miss_clear: assert property (
    q.blk.sync == spc_pkg::SPC_UNSYNC && block_tick_i && !blk_agree |=> q.blk.cnt == 4'h0)
    else $error("unsynced counter not cleared");
  a_no_tick_hold: assert property (!block_tick_i && !srst |=> $stable(q.blk))
    else $error("block counter moved without a tick");
  a_synced_agree_clear: assert property (
    q.blk.sync == spc_pkg::SPC_SYNCED && block_tick_i && blk_agree |=> q.blk.cnt == 4'h0)
    else $error("synced counter not cleared on agreement");
  a_sync_switch_point: assert property (
    q.blk.sync == spc_pkg::SPC_UNSYNC && block_tick_i && blk_agree && !srst
      && q.blk.cnt == q.block_counts[7:4] |=> q.blk.sync == spc_pkg::SPC_SYNCED ##1 block_sync_o)
    else $error("block sync did not switch at programmed value");
  a_sync_reset_clear: assert property (srst |=> q.blk.sync == spc_pkg::SPC_UNSYNC
                                       && q.frm.sync == spc_pkg::SPC_UNSYNC && q.frm.cnt == 4'h0)
    else $error("sync reset did not clear state");
  a_reset_gates_pins: assert property (srst |=> !event_strobe_o && !serial_oe_o && !pkt_emit_o)
    else $error("strobe or pin active during sync reset");
  a_crc_reset_follow: assert property (upper_crc_checker_reset_o == $past(q.ctl[7], 1))
    else $error("checker reset does not follow control");
  a_shutdown_stops: assert property (q.ctl[3] |=> !correction_enable_o && !column_correction_enable_o)
    else $error("correction still enabled in shutdown");

  // ----------------------------------------------------------------
  // Register writes and control outputs
  // ----------------------------------------------------------------
  a_block_count_write: assert property (
    wr_i && addr_i == spc_pkg::BLOCK_COUNTS_ADDR |=> q.block_counts == $past(wdata_i))
    else $error("block counts write lost");
  a_frame_count_write: assert property (
    wr_i && addr_i == spc_pkg::FRAME_COUNTS_ADDR |=> q.frame_counts == $past(wdata_i))
    else $error("frame counts write lost");
  a_ctl_reset_value: assert property ($fell(rst_i) |-> q.ctl == 8'h00)
    else $error("control register not at reset value");
  a_method_follow: assert property (method_a_o == $past(q.ctl[0]))
    else $error("method output does not follow control");
  a_column_disable: assert property (q.ctl[2] |=> !column_correction_enable_o)
    else $error("column correction still enabled");

  // ----------------------------------------------------------------
  // Block protection
  // ----------------------------------------------------------------
  a_err_limit_unsync: assert property (
    q.blk.sync == spc_pkg::SPC_UNSYNC && code_found_i
      && code_errors_i <= unsynced_err_limit_i |-> blk_agree)
    else $error("code within unsynced limit not accepted");
  a_err_limit_synced: assert property (
    q.blk.sync == spc_pkg::SPC_SYNCED && code_found_i
      && code_errors_i <= synced_err_limit_i |-> blk_agree)
    else $error("code within synced limit not accepted");
  a_synced_miss_incr: assert property (
    q.blk.sync == spc_pkg::SPC_SYNCED && block_tick_i && !blk_agree && !srst
      && q.blk.cnt != q.block_counts[3:0] |=> q.blk.cnt == $past(q.blk.cnt) + 4'h1)
    else $error("synced counter did not increment on deviation");
  a_block_drop_point: assert property (
    q.blk.sync == spc_pkg::SPC_SYNCED && block_tick_i && !blk_agree && !srst
      && q.blk.cnt == q.block_counts[3:0] |=> q.blk.sync == spc_pkg::SPC_UNSYNC)
    else $error("block sync did not drop at forward value");
  a_zero_count_follow: assert property (
    q.block_counts == 8'h00 && block_tick_i && !srst
      |=> (q.blk.sync == spc_pkg::SPC_SYNCED) == $past(blk_agree))
    else $error("zero protection does not follow each judgement");
  a_block_sync_output: assert property (
    block_sync_o == $past(q.blk.sync == spc_pkg::SPC_SYNCED))
    else $error("block sync output does not follow state");

  // ----------------------------------------------------------------
  // Frame protection
  // ----------------------------------------------------------------
  a_frame_unsync_incr: assert property (
    q.frm.sync == spc_pkg::SPC_UNSYNC && frame_tick_i && frm_agree && !srst
      && q.frm.cnt != q.frame_counts[7:4] |=> q.frm.cnt == $past(q.frm.cnt) + 4'h1)
    else $error("frame counter did not increment");
  a_frame_miss_clear: assert property (
    q.frm.sync == spc_pkg::SPC_UNSYNC && frame_tick_i && !frm_agree |=> q.frm.cnt == 4'h0)
    else $error("frame counter not cleared");
  a_frame_no_tick_hold: assert property (!frame_tick_i && !srst |=> $stable(q.frm))
    else $error("frame counter moved without a tick");
  a_frame_sync_switch: assert property (
    q.frm.sync == spc_pkg::SPC_UNSYNC && frame_tick_i && frm_agree && !srst
      && q.frm.cnt == q.frame_counts[7:4] |=> q.frm.sync == spc_pkg::SPC_SYNCED)
    else $error("frame sync did not switch at backward value");
  a_frame_drop_point: assert property (
    q.frm.sync == spc_pkg::SPC_SYNCED && frame_tick_i && !frm_agree && !srst
      && q.frm.cnt == q.frame_counts[3:0] |=> q.frm.sync == spc_pkg::SPC_UNSYNC)
    else $error("frame sync did not drop at forward value");
  a_frame_sync_output: assert property (
    frame_sync_o == $past(q.frm.sync == spc_pkg::SPC_SYNCED))
    else $error("frame sync output does not follow state");
  a_no_realtime_blocks_change_drop: assert property (
    q.ctl[1] != q.no_no_realtime_blocks && q.frm.sync == spc_pkg::SPC_SYNCED && !srst |=> q.no_realtime_blocks_drop)
    else $error("block layout change did not start frame drop");
  a_no_realtime_blocks_drop_miss: assert property (q.no_realtime_blocks_drop |-> !frm_agree)
    else $error("frame agreement seen during layout change drop");

  // ----------------------------------------------------------------
  // Datapath gating
  // ----------------------------------------------------------------
  a_strobe_follow: assert property (!srst |=> event_strobe_o == $past(event_strobe_i))
    else $error("event strobe not passed through");
  a_pin_mode_drive: assert property (q.ctl[6] && !q.ctl[4] && !q.ctl[3] |=> serial_oe_o)
    else $error("serial pin not driven in follow mode");
  a_pin_data_follow: assert property (serial_data_o == $past(serial_data_i))
    else $error("serial data not passed through");
  a_emit_all: assert property (
    q.ctl[5] && pkt_valid_i && !q.ctl[4] && !q.ctl[3] |=> pkt_emit_o)
    else $error("packet not emitted in emit-all mode");
  a_emit_needs_sync: assert property (
    !q.ctl[5] && q.blk.sync == spc_pkg::SPC_UNSYNC |=> !pkt_emit_o)
    else $error("packet emitted while unsynced");

endmodule : spc_sync_protection_control

// ### core/spc_pkg.sv
// Constants, types and field layout for the sync protection and control bank.
// Assumes a host-port front end that delivers single-cycle writes on the core clock.
package spc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] BLOCK_COUNTS_ADDR = 4'h2;
  localparam logic [3:0] FRAME_COUNTS_ADDR = 4'h3;
  localparam logic [3:0] MAIN_CONTROL_ADDR = 4'h4;

  localparam logic [7:0] BLOCK_COUNTS_RESET = 8'h17;
  localparam logic [7:0] FRAME_COUNTS_RESET = 8'h17;
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [3:0] ERR_LIMIT_RESET    = 4'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BACKWARD_MSB       = 7;
  localparam int BACKWARD_LSB       = 4;
  localparam int FORWARD_MSB        = 3;
  localparam int FORWARD_LSB        = 0;
  localparam int CRC_RESET_BIT      = 7;
  localparam int PIN_MODE_BIT       = 6;
  localparam int EMIT_ALL_BIT       = 5;
  localparam int SYNC_RESET_BIT     = 4;
  localparam int SHUTDOWN_BIT       = 3;
  localparam int COLUMN_DISABLE_BIT = 2;
  localparam int NO_NO_REALTIME_BLOCKS_BIT        = 1;
  localparam int METHOD_A_BIT       = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    SPC_UNSYNC = 1'b0,
    SPC_SYNCED = 1'b1
  } spc_sync_type;

  typedef struct packed {
    spc_sync_type sync;
    logic [3:0]   cnt;
  } spc_prot_type;

endpackage : spc_pkg

// ### testbench/spc_host_model.sv
// Host processor model that writes the configuration registers.
// Assumes writes launch on the falling edge of core_clk_i.
`timescale 1ns/1ps

module spc_host_model (
  input  wire logic       core_clk_i,
  output logic            wr_o,
  output logic [3:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    wr_o    = 1'b0;
    addr_o  = 4'hF;
    wdata_o = 8'hA5;
  end

  // Whole-byte write, one cycle; idle bus shows inverted last value
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge core_clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : write_reg
endmodule : spc_host_model

// ### testbench/spc_sync_protection_control_bench.sv
// Self-checking bench for the sync protection and control bank.
// Assumes the host model and design compiled before this file.
`timescale 1ns/1ps

module spc_sync_protection_control_bench;
  logic       core_clk_i, rst_i, wr, btk, found, ftk, fagree, es, sd, act, pv, ok;
  logic [3:0] addr, errs;
  logic [7:0] wdata;
  logic       bsync, fsync, crc_rst, corr, col, meth, nort, es_o, sd_o, oe, emit;
  int         err_total = 0;
  int         n_tests   = 0;

  spc_host_model u_host (.core_clk_i(core_clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  spc_sync_protection_control u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .wr_i(wr), .addr_i(addr), .wdata_i(wdata),
    .synced_err_limit_i(4'h3), .unsynced_err_limit_i(4'h2), .block_tick_i(btk),
    .code_found_i(found), .code_errors_i(errs), .frame_tick_i(ftk), .frame_agree_i(fagree),
    .event_strobe_i(es), .serial_data_i(sd), .serial_active_i(act), .pkt_valid_i(pv),
    .pkt_corrected_i(1'b1), .pkt_crc_ok_i(ok), .block_sync_o(bsync), .frame_sync_o(fsync),
    .upper_crc_checker_reset_o(crc_rst), .correction_enable_o(corr),
    .column_correction_enable_o(col), .method_a_o(meth), .no_realtime_blocks_o(nort),
    .event_strobe_o(es_o), .serial_data_o(sd_o), .serial_oe_o(oe), .pkt_emit_o(emit));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
    cyc(1);
  endtask : wreg

  task automatic btick(input logic f, input logic [3:0] e);
    cyc(1);
    btk   = 1'b1;
    found = f;
    errs  = e;
    cyc(1);
    btk = 1'b0;
  endtask : btick

  task automatic ftick(input logic a);
    cyc(1);
    ftk    = 1'b1;
    fagree = a;
    cyc(1);
    ftk = 1'b0;
  endtask : ftick

  task automatic see_blk(input logic e);
    cyc(1);
    chk("block_sync", e, bsync);
  endtask : see_blk

  task automatic see_frm(input logic e);
    cyc(1);
    chk("frame_sync", e, fsync);
  endtask : see_frm

  task automatic dp(input logic s, input logic a, input logic p, input logic k);
    cyc(1);
    es  = s;
    act = a;
    sd  = a;
    pv  = p;
    ok  = k;
    cyc(1);
    pv = 1'b0;
  endtask : dp

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_control;
    chk("method_a", 1'b0, meth);
    chk("corr_en", 1'b1, corr);
    wreg(4'h4, 8'h8B);
    chk("crc_reset", 1'b1, crc_rst);
    chk("corr_en", 1'b0, corr);
    chk("col_en", 1'b0, col);
    chk("no_rt", 1'b1, nort);
    chk("method_a", 1'b1, meth);
    wreg(4'h5, 8'h00);
    chk("crc_reset", 1'b1, crc_rst);
    wreg(4'h4, 8'h04);
    chk("crc_reset", 1'b0, crc_rst);
    chk("corr_en", 1'b1, corr);
    chk("col_en", 1'b0, col);
  endtask : t_control

  task automatic t_datapath;
    dp(1'b1, 1'b0, 1'b1, 1'b0);
    chk("strobe", 1'b1, es_o);
    chk("pin_oe", 1'b0, oe);
    chk("emit", 1'b0, emit);
    dp(1'b0, 1'b1, 1'b0, 1'b0);
    chk("pin_data", 1'b1, sd_o);
    wreg(4'h4, 8'h64);
    dp(1'b0, 1'b0, 1'b1, 1'b0);
    chk("pin_oe", 1'b1, oe);
    chk("emit", 1'b1, emit);
    wreg(4'h4, 8'h14);
    dp(1'b1, 1'b1, 1'b0, 1'b0);
    chk("strobe", 1'b0, es_o);
    chk("pin_oe", 1'b0, oe);
    wreg(4'h4, 8'h04);
  endtask : t_datapath

  task automatic t_block;
    btick(1'b1, 4'h2);
    cyc(3);
    see_blk(1'b0);
    btick(1'b1, 4'h3);
    btick(1'b1, 4'h2);
    see_blk(1'b0);
    btick(1'b1, 4'h0);
    see_blk(1'b1);
    repeat (7) btick(1'b0, 4'h0);
    btick(1'b1, 4'h3);
    repeat (7) btick(1'b0, 4'h0);
    see_blk(1'b1);
    btick(1'b0, 4'h0);
    see_blk(1'b0);
    wreg(4'h2, 8'h22);
    repeat (2) btick(1'b1, 4'h0);
    see_blk(1'b0);
    btick(1'b1, 4'h0);
    see_blk(1'b1);
    repeat (2) btick(1'b0, 4'h0);
    see_blk(1'b1);
    btick(1'b0, 4'h0);
    see_blk(1'b0);
    wreg(4'h2, 8'h00);
    btick(1'b1, 4'h0);
    see_blk(1'b1);
    btick(1'b0, 4'h0);
    see_blk(1'b0);
  endtask : t_block

  task automatic t_frame;
    wreg(4'h3, 8'h11);
    ftick(1'b1);
    see_frm(1'b0);
    ftick(1'b1);
    see_frm(1'b1);
    wreg(4'h4, 8'h06);
    ftick(1'b1);
    see_frm(1'b1);
    ftick(1'b1);
    see_frm(1'b0);
    repeat (2) ftick(1'b1);
    btick(1'b1, 4'h0);
    see_frm(1'b1);
    wreg(4'h4, 8'h16);
    see_frm(1'b0);
    btick(1'b1, 4'h0);
    see_blk(1'b0);
    wreg(4'h4, 8'h06);
    btick(1'b1, 4'h0);
    see_blk(1'b1);
  endtask : t_frame

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_total++;
    report_and_stop();
  end

  initial begin
    {rst_i, btk, found, errs, ftk, fagree, es, sd, act, pv, ok} = {1'b1, 13'h0};
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_control();
    t_datapath();
    t_block();
    t_frame();
    report_and_stop();
  end
endmodule : spc_sync_protection_control_bench
